/* File: design/pab_regs.vh */
`ifndef PAB_REGS_VH
`define PAB_REGS_VH
// mode strap encodings
`define PAB_MODE_HOST      1'b0
`define PAB_MODE_SATELLITE 1'b1
// grant line 1 is unknown for this many clocks after reset before its value
`define PAB_GNT1_X_CLKS    2'h1
// arbiter state codes
`define PAB_ST_IDLE        2'h0
`define PAB_ST_GRANT       2'h1
`endif

/* File: design/pab_arbiter.v */
`timescale 1ns/1ps
// Behaviour
// - host mode: pci reset clears pci logic only
// - satellite mode: pci reset clears pci logic and requests a device warm reset
// - host mode: three request lines are inputs from external masters
// - satellite mode: request line 2 acts as idsel for configuration cycles
// - satellite mode: request line 1 is ignored
// - satellite mode: request line 0 drives this device's own bus request
// - host mode: three grant lines are active-low outputs to external masters
// - satellite mode: grant line 2 is open-collector interrupt a output
// - reset: grant 2 floats in host and boot, low in non-boot satellite
// - satellite mode: grant line 1 is eeprom chip select, output at reset
// - reset: grant 1 unknown one clock, then high host, low satellite
// - satellite mode: grant line 0 is input grant from external arbiter
`include "pab_regs.vh"

module pab_arbiter (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       mode_strap,
  input  wire       boot_strap,
  input  wire       pci_rst_n,
  input  wire [2:0] req_n_in,
  output reg  [2:0] req_n_out,
  output reg  [2:0] req_n_oe,
  input  wire [2:0] gnt_n_in,
  output reg  [2:0] gnt_n_out,
  output reg  [2:0] gnt_n_oe,
  input  wire       lock_n_in,
  input  wire       own_req,
  input  wire       int_req,
  input  wire       eeprom_cs,
  output reg        own_gnt,
  output reg        idsel,
  output reg        lock_seen,
  output reg        pci_logic_rst,
  output reg        warm_rst,
  output reg        satellite,
  output reg        boot
);

  reg  [2:0] req_s1;
  reg  [2:0] req_s2;
  reg  [2:0] gnt_s1;
  reg  [2:0] gnt_s2;
  reg  [1:0] rst_s;
  reg  [1:0] lock_s;
  reg  [1:0] x_cnt;
  reg  [1:0] state;
  reg  [1:0] owner;
  reg  [1:0] next_owner;
  reg        next_found;
  reg  [2:0] gnt_vec;
  wire       pci_rst;
  integer    i;
  integer    idx;

  // pin inputs other than the two straps pass two flops before any logic reads them
  always @(posedge ref_clk) begin
    req_s1 <= req_n_in;
    req_s2 <= req_s1;
    gnt_s1 <= gnt_n_in;
    gnt_s2 <= gnt_s1;
    rst_s  <= {rst_s[0], pci_rst_n};
    lock_s <= {lock_s[0], lock_n_in};
  end

  assign pci_rst = ~rst_s[1];

  // straps caught while cold reset is held, fixed after release
  always @(posedge ref_clk) begin
    if (srst) begin
      satellite <= mode_strap;
      boot      <= boot_strap;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pci_logic_rst <= 1'b1;
      warm_rst      <= 1'b0;
    end else begin
      pci_logic_rst <= pci_rst;
      warm_rst      <= pci_rst & satellite;
    end
  end

  // round-robin search starting after the current owner, so no master starves
  always @* begin
    next_owner = owner;
    next_found = 1'b0;
    idx        = 0;
    for (i = 1; i <= 3; i = i + 1) begin
      idx = (owner + i) % 3;
      if (!next_found && !req_s2[idx]) begin
        next_owner = idx[1:0];
        next_found = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst || pci_rst || satellite) begin
      state <= `PAB_ST_IDLE;
      owner <= 2'h2;
    end else begin
      case (state)
        `PAB_ST_IDLE: begin
          if (next_found) begin
            owner <= next_owner;
            state <= `PAB_ST_GRANT;
          end
        end
        `PAB_ST_GRANT: begin
          // hold grant while owner requests or a locked operation runs
          if (req_s2[owner] && lock_s[1]) begin
            state <= `PAB_ST_IDLE;
          end
        end
        default: state <= `PAB_ST_IDLE;
      endcase
    end
  end

  always @* begin
    gnt_vec = 3'h7;
    if (state == `PAB_ST_GRANT) begin
      gnt_vec[owner] = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      x_cnt <= 2'h0;
    end else if (x_cnt != `PAB_GNT1_X_CLKS) begin
      x_cnt <= x_cnt + 2'h1;
    end
  end

  // pin drive; satellite roles never change after cold reset
  always @(posedge ref_clk) begin
    if (srst) begin
      req_n_out <= 3'h7;
      req_n_oe  <= 3'h0;
      // grant 2 pulled low through cold reset only in satellite non-boot
      gnt_n_out <= 3'h3;
      gnt_n_oe  <= {mode_strap & ~boot_strap, 2'h0};
      own_gnt   <= 1'b0;
      idsel     <= 1'b0;
      lock_seen <= 1'b0;
    end else begin
      lock_seen <= ~lock_s[1];
      if (!satellite) begin
        req_n_out <= 3'h7;
        req_n_oe  <= 3'h0;
        own_gnt   <= 1'b0;
        idsel     <= 1'b0;
        gnt_n_out[2] <= pci_rst ? 1'b1 : gnt_vec[2];
        gnt_n_oe[2]  <= ~pci_rst;
        gnt_n_out[1] <= pci_rst ? 1'b1 : gnt_vec[1];
        gnt_n_oe[1]  <= (x_cnt == `PAB_GNT1_X_CLKS);
        gnt_n_out[0] <= gnt_vec[0];
        gnt_n_oe[0]  <= ~pci_rst;
      end else begin
        idsel        <= ~req_s2[2];
        req_n_out    <= {2'h3, ~(own_req & ~pci_rst)};
        req_n_oe     <= 3'h1;
        own_gnt      <= ~gnt_s2[0] & ~pci_rst;
        gnt_n_out[0] <= 1'b1;
        gnt_n_oe[0]  <= 1'b0;
        // open collector: drive low only, never high
        gnt_n_out[2] <= 1'b0;
        gnt_n_oe[2]  <= pci_rst ? ~boot : int_req;
        // select is active high on the pin, so the low reset level deselects
        gnt_n_out[1] <= pci_rst ? 1'b0 : eeprom_cs;
        gnt_n_oe[1]  <= (x_cnt == `PAB_GNT1_X_CLKS);
      end
    end
  end

  // devsel is produced by the target decoder elsewhere; idsel feeds it

endmodule // pab_arbiter

/* File: test/pab_far.sv */
`timescale 1ns/1ps
module pab_far (
  input  logic [2:0] want, ext_gnt, req_n_out, req_n_oe, gnt_n_out, gnt_n_oe,
  output logic [2:0] req_n_in, gnt_n_in
);
  // the far end drives ~want and ~ext_gnt wherever this device does not, so a released pin never shows stale data
  assign req_n_in = req_n_oe & req_n_out | ~req_n_oe & ~want;
  assign gnt_n_in = gnt_n_oe & gnt_n_out | ~gnt_n_oe & ~ext_gnt;
endmodule // pab_far

/* File: test/pab_arbiter_chk.sv */
`timescale 1ns/1ps
module pab_arbiter_chk (
  input ref_clk, srst, pci_rst_n, lock_n_in, int_req, own_gnt, pci_logic_rst, warm_rst,
  satellite, boot,
  input [2:0] req_n_in, gnt_n_in, req_n_oe, gnt_n_out, gnt_n_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire run = satellite && !pci_logic_rst;
  a_host_warm: assert property (!satellite |-> !warm_rst)
    else $error("warm");
  a_sat_warm: assert property ((satellite && !pci_rst_n)[*4] |-> warm_rst)
    else $error("nowarm");
  a_req_dir: assert property (req_n_oe[2:1] == 2'h0 && (satellite || !req_n_oe[0]))
    else $error("req");
  a_host_gnt: assert property (
    (!satellite && !pci_logic_rst && lock_n_in && req_n_in == 3'h6)[*8] |-> !gnt_n_out[0])
    else $error("gnt");
  a_host_pins: assert property (
    !satellite && !pci_logic_rst && !$past(srst, 3) |-> gnt_n_oe == 3'h7 && $onehot0(~gnt_n_out))
    else $error("pins");
  a_sat_inta: assert property (run ##1 run |-> gnt_n_oe[2] == $past(int_req))
    else $error("inta");
  a_own_gnt: assert property ((run && !gnt_n_in[0])[*4] |-> own_gnt)
    else $error("own");
  a_strap_hold: assert property ($stable(satellite) && $stable(boot))
    else $error("strap");
  cover property (gnt_n_out == 3'h6);
  cover property (warm_rst);
  cover property (own_gnt);
endmodule // pab_arbiter_chk
bind pab_arbiter pab_arbiter_chk pab_arbiter_chk_i (.*);

/* File: test/pab_arbiter_tb.sv */
`timescale 1ns/1ps
module pab_arbiter_tb;
  logic ref_clk = 0, srst = 1, mode_strap = 0, boot_strap = 0, pci_rst_n = 1, lock_n_in = 1;
  logic own_req = 0, int_req = 0, eeprom_cs = 0, own_gnt, idsel, lock_seen, pci_logic_rst;
  logic warm_rst, satellite, boot;
  logic [2:0] want = 0, ext_gnt = 0, req_n_in, req_n_out, req_n_oe, gnt_n_in, gnt_n_out, gnt_n_oe;
  int err_total = 0, n_compared = 0, j, k;
  pab_far pab_far_i (.*);
  pab_arbiter pab_arbiter_i (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task chk(input logic [3:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t %h %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("n %0d err %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task go(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  initial begin
    void'($urandom(88412));
    // host, satellite non-boot, satellite boot
    for (j = 0; j < 3; j++) begin
      srst <= 1;
      {own_req, int_req, eeprom_cs, ext_gnt, want, lock_n_in} <= 10'h001;
      mode_strap <= j > 0;
      boot_strap <= j > 1;
      go(20);
      chk(gnt_n_oe[2], j == 1);
      srst <= 0;
      go(4);
      chk({gnt_n_oe[1], gnt_n_out[1]}, {1'b1, j == 0});
      for (k = 0; k < 12; k++) begin
        if (j == 0) want <= 3'h1 << k % 3;
        else {lock_n_in, own_req, int_req, eeprom_cs, ext_gnt[0], want[2:1]} <= 7'($urandom);
        go(10);
        if (j == 0) chk(gnt_n_out, {1'b0, ~(3'h1 << k % 3)});
        else chk({own_gnt, idsel, req_n_out[0], gnt_n_out[1]},
          {ext_gnt[0], want[2], !own_req, eeprom_cs});
        if (j > 0) chk({gnt_n_oe[2], gnt_n_out[2], lock_seen}, {int_req, 1'b0, !lock_n_in});
      end
      pci_rst_n <= 0;
      go(6);
      chk({pci_logic_rst, warm_rst}, {1'b1, j > 0});
      pci_rst_n <= 1;
    end
    end_of_test;
  end
endmodule // pab_arbiter_tb
